//--- hdl/nvs_pkg.sv
// Constants, types and helper functions for the serial nonvolatile RAM slave.
// Assumes nothing of its surroundings; shared by the array and slave design files and the bench.
`default_nettype none

package nvs_pkg;

   // Array geometry
   localparam int ADDR_W = 11;
   localparam int MEM_DEPTH = 2048;

   // Command bytes
   localparam logic [7:0] OP_SET_LATCH = 8'h06;
   localparam logic [7:0] OP_CLR_LATCH = 8'h04;
   localparam logic [7:0] OP_STAT_RD = 8'h05;
   localparam logic [7:0] OP_STAT_WR = 8'h01;
   localparam logic [7:0] OP_MEM_RD = 8'h03;
   localparam logic [7:0] OP_MEM_WR = 8'h02;

   // Protected ranges start here and run to the top of the array
   localparam logic [ADDR_W-1:0] PROT_QTR_BASE = 11'h600;
   localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 11'h400;

   // Status byte bit positions
   localparam int ST_WPEN_POS = 7;
   localparam int ST_BP_HI_POS = 3;
   localparam int ST_BP_LO_POS = 2;
   localparam int ST_WEL_POS = 1;

   // Bit counter and link limits
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] FIRST_BIT = 3'h0;
   localparam int SCK_MAX_MHZ = 20;

   // Reset values of the clock-domain status view (standby high, rest low) and of the status-lock synchroniser (high)
   localparam logic [3:0] VIEW_RST = 4'h8;
   localparam logic WP_SYNC_RST = 1'b1;

   typedef enum logic [2:0] {
      ST_CMD  = 3'h0,
      ST_ADDR = 3'h1,
      ST_DATA = 3'h3,
      ST_STAT = 3'h2,
      ST_SKIP = 3'h6
   } nvs_state_t;

   typedef struct packed {
      logic wpen;
      logic block_protect_hi;
      logic block_protect_lo;
      logic write_latch_flag;
   } nvs_stat_t;

   localparam nvs_stat_t STAT_RST = '0;

   function automatic logic nvs_protected(input logic hi, input logic lo, input logic [ADDR_W-1:0] a);
      logic p;
      p = 1'b0;
      if (hi && lo) begin
         p = 1'b1;
      end else if (hi) begin
         p = (a >= PROT_HALF_BASE);
      end else if (lo) begin
         p = (a >= PROT_QTR_BASE);
      end
      return p;
   endfunction : nvs_protected

   function automatic logic [7:0] nvs_stat_byte(input nvs_stat_t s);
      logic [7:0] b;
      b = 8'h00;
      b[ST_WPEN_POS] = s.wpen;
      b[ST_BP_HI_POS] = s.block_protect_hi;
      b[ST_BP_LO_POS] = s.block_protect_lo;
      b[ST_WEL_POS] = s.write_latch_flag;
      return b;
   endfunction : nvs_stat_byte

endpackage : nvs_pkg

`default_nettype wire

//--- hdl/nvs_sync.sv
// Two-stage level synchroniser, one bit per lane.
// Assumes d is a slow level; rst is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module nvs_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   if (WIDTH < 1) begin : g_chk
      $error("nvs_sync: WIDTH must be at least 1");
   end

   // First stage feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : nvs_sync

`default_nettype wire

//--- hdl/nvs_mem_array.sv
// Byte-wide array held in flip-flops, written on the link clock, read combinationally.
// Assumes write strobe and address are stable around the rising link clock edge.
`timescale 1ns/1ps
`default_nettype none

module nvs_mem_array #(
   parameter int AW = nvs_pkg::ADDR_W,
   parameter int DEPTH = nvs_pkg::MEM_DEPTH
) (
   // Link clock
   input wire logic clk,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [7:0] wdata,
   // Read port
   input wire logic [AW-1:0] raddr,
   output logic [7:0] rdata
);
   logic [7:0] cells [DEPTH];

   if (DEPTH != (1 << AW)) begin : g_chk
      $error("nvs_mem_array: DEPTH must equal 2**AW");
   end

   // Nonvolatile contents: deliberately no reset
   always_ff @(posedge clk) begin
      if (we) begin
         cells[waddr] <= wdata;
      end
   end

   assign rdata = cells[raddr];
endmodule : nvs_mem_array

`default_nettype wire

//--- hdl/nvs_spi_slave.sv
// Serial-peripheral slave front end of a 2048-byte nonvolatile RAM.
// Assumes a host master in clock mode 0 or 3; srst is released while cs_n is high.
//
// Summary of operation
// - Select high: standby, other inputs ignored, outputs high impedance.
// - Serial clock acts on internal logic only while select is low, except the status-lock synchroniser, which samples on every rising edge.
// - Sample input on rising clock edges, change output on falling edges.
// - Static logic: any clock rate up to 20 MHz, clock may stop.
// - Clock modes 0,0 and 1,1 both accepted.
// - Suspend low freezes operation and ignores clock edges.
// - Status-lock low refuses status writes, not memory writes.
// - Output driven only while returning read data, never during suspend.
// - Array holds 2048 individually addressed bytes.
// - Access is select, command byte, two address bytes, then data.
// - Only the low eleven address bits are decoded.
// - Each write byte commits on its last bit, no extra delay.
// - Device is never busy; no polling needed.
// - Power-on reset is the only reset and leaves writes disabled.
// - Command bytes 06, 04, 05, 01, 03, 02 decoded as listed.
// - Write latch set, cleared, and cleared after each completed write.
// - Block-protect bits select none, 600h-7FFh, 400h-7FFh or all.
// - Whole bytes, most significant bit first.
`timescale 1ns/1ps
`default_nettype none

module nvs_spi_slave (
   // System clock domain
   input wire logic clock,
   input wire logic srst,
   // Serial link
   input wire logic spi_clock,
   input wire logic cs_n,
   input wire logic si,
   input wire logic hold_n,
   input wire logic wp_n,
   output logic so,
   output logic so_oe,
   // Status view on the system clock
   output logic standby,
   output logic write_latch_flag,
   output logic block_protect_hi,
   output logic block_protect_lo
);
   import nvs_pkg::*;

   // Frame state, cleared by select release
   nvs_state_t state, next_state;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [6:0] shift, next_shift;
   logic [7:0] cmd, next_cmd;
   logic [ADDR_W-1:0] addr, next_addr;
   logic addr_hi, next_addr_hi;
   logic write_ok, next_write_ok;

   // Persistent state, cleared by power-on reset only
   nvs_stat_t stat, next_stat;

   // Output stage on the falling edge
   logic next_so, next_so_oe;
   logic out_kill;

   logic [7:0] rx;
   logic [7:0] out_byte;
   logic [7:0] mem_rdata;
   logic frame_live;
   logic last_bit;
   logic mem_we;
   logic stat_we;
   logic latch_set;
   logic latch_clr;
   logic write_done;
   logic wp_ok;
   logic [3:0] view;

   assign frame_live = !cs_n && hold_n;
   assign last_bit = (bit_cnt == LAST_BIT);
   assign out_kill = cs_n || !hold_n;

   // Status-lock pin is asynchronous to the link clock
   nvs_sync #(.WIDTH(1), .RST_VAL(WP_SYNC_RST)) u_wp_sync (
      .clk(spi_clock),
      .rst(1'b0),
      .d(wp_n),
      .q(wp_ok)
   );

   nvs_mem_array #(.AW(ADDR_W), .DEPTH(MEM_DEPTH)) u_mem (
      .clk(spi_clock),
      .we(mem_we),
      .waddr(addr),
      .wdata(rx),
      .raddr(addr),
      .rdata(mem_rdata)
   );

   // Frame decoder; a partial byte never reaches a commit
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shift = shift;
      next_cmd = cmd;
      next_addr = addr;
      next_addr_hi = addr_hi;
      next_write_ok = write_ok;
      rx = {shift, si};
      mem_we = 1'b0;
      stat_we = 1'b0;
      latch_set = 1'b0;
      latch_clr = 1'b0;
      write_done = 1'b0;
      if (frame_live) begin
         next_bit_cnt = bit_cnt + 3'h1;
         next_shift = rx[6:0];
         if (last_bit) begin
            case (state)
               ST_CMD: begin
                  next_cmd = rx;
                  next_state = ST_SKIP;
                  if (rx == OP_SET_LATCH) begin
                     latch_set = 1'b1;
                  end else if (rx == OP_CLR_LATCH) begin
                     latch_clr = 1'b1;
                  end else if (rx == OP_STAT_RD || rx == OP_STAT_WR) begin
                     next_state = ST_STAT;
                     next_write_ok = stat.write_latch_flag && (rx == OP_STAT_WR);
                  end else if (rx == OP_MEM_RD || rx == OP_MEM_WR) begin
                     next_state = ST_ADDR;
                     next_write_ok = stat.write_latch_flag && (rx == OP_MEM_WR);
                  end
               end
               ST_ADDR: begin
                  if (!addr_hi) begin
                     next_addr_hi = 1'b1;
                     next_addr = {rx[ADDR_W-9:0], addr[7:0]};
                  end else begin
                     next_addr = {addr[ADDR_W-1:8], rx};
                     next_state = ST_DATA;
                  end
               end
               ST_DATA: begin
                  // Sequential access wraps at the top of the array
                  next_addr = addr + 11'h001;
                  if (write_ok) begin
                     write_done = 1'b1;
                     mem_we = !nvs_protected(stat.block_protect_hi, stat.block_protect_lo, addr);
                  end
               end
               ST_STAT: begin
                  next_state = ST_SKIP;
                  if (write_ok) begin
                     write_done = 1'b1;
                     stat_we = wp_ok;
                  end
               end
               default: begin
                  next_state = ST_SKIP;
               end
            endcase
         end
      end
   end

   // Pure edge logic with no timers, so any clock rate and a stopped clock keep state
   always_ff @(posedge spi_clock or posedge cs_n) begin
      if (cs_n) begin
         state <= ST_CMD;
         bit_cnt <= FIRST_BIT;
         shift <= 7'h00;
         cmd <= 8'h00;
         addr <= 11'h000;
         addr_hi <= 1'b0;
         write_ok <= 1'b0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         cmd <= next_cmd;
         addr <= next_addr;
         addr_hi <= next_addr_hi;
         write_ok <= next_write_ok;
      end
   end

   // Latch clears on the first completed write so later bytes of the same frame still land
   always_comb begin
      next_stat = stat;
      if (latch_set) begin
         next_stat.write_latch_flag = 1'b1;
      end
      if (latch_clr || write_done) begin
         next_stat.write_latch_flag = 1'b0;
      end
      if (stat_we) begin
         next_stat.wpen = rx[ST_WPEN_POS];
         next_stat.block_protect_hi = rx[ST_BP_HI_POS];
         next_stat.block_protect_lo = rx[ST_BP_LO_POS];
      end
   end

   // Power-on reset asserts without a link edge; the link clock may be stopped
   always_ff @(posedge spi_clock or posedge srst) begin
      if (srst) begin
         stat <= STAT_RST;
      end else begin
         stat <= next_stat;
      end
   end

   // Output stage; status read never reports busy
   always_comb begin
      out_byte = (state == ST_STAT) ? nvs_stat_byte(stat) : mem_rdata;
      next_so = out_byte[LAST_BIT - bit_cnt];
      next_so_oe = (state == ST_DATA && cmd == OP_MEM_RD) ||
                   (state == ST_STAT && cmd == OP_STAT_RD);
   end

   always_ff @(negedge spi_clock or posedge out_kill) begin
      if (out_kill) begin
         so <= 1'b0;
         so_oe <= 1'b0;
      end else begin
         so <= next_so;
         so_oe <= next_so_oe;
      end
   end

   // Status view crosses into the system clock domain
   nvs_sync #(.WIDTH(4), .RST_VAL(VIEW_RST)) u_view_sync (
      .clk(clock),
      .rst(srst),
      .d({cs_n, stat.write_latch_flag, stat.block_protect_hi, stat.block_protect_lo}),
      .q(view)
   );

   assign standby = view[3];
   assign write_latch_flag = view[2];
   assign block_protect_hi = view[1];
   assign block_protect_lo = view[0];

   // Checks
   sequence s_cmd_done(logic [7:0] op);
      frame_live && state == ST_CMD && last_bit && rx == op;
   endsequence

   sequence s_addr_done;
      frame_live && state == ST_ADDR && last_bit && addr_hi;
   endsequence

   property p_standby_quiet;
      @(posedge clock) disable iff (srst) cs_n |-> !so_oe;
   endproperty
   a_standby_quiet: assert property (p_standby_quiet) else $error("output enabled while deselected");

   property p_latch_set;
      @(posedge spi_clock) disable iff (srst) s_cmd_done(OP_SET_LATCH) |=> stat.write_latch_flag;
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("latch not set by enable command");

   property p_latch_clr;
      @(posedge spi_clock) disable iff (srst) s_cmd_done(OP_CLR_LATCH) |=> !stat.write_latch_flag;
   endproperty
   a_latch_clr: assert property (p_latch_clr) else $error("latch not cleared by disable command");

   property p_read_path;
      @(posedge spi_clock) disable iff (cs_n || srst)
         s_cmd_done(OP_MEM_RD) |=> (state == ST_ADDR && !addr_hi && bit_cnt == FIRST_BIT);
   endproperty
   a_read_path: assert property (p_read_path) else $error("command not followed by address framing");

   property p_addr_to_data;
      @(posedge spi_clock) disable iff (cs_n || srst) s_addr_done |=> (state == ST_DATA && addr_hi);
   endproperty
   a_addr_to_data: assert property (p_addr_to_data) else $error("address not followed by data");

   property p_lock_refuses;
      @(posedge spi_clock) disable iff (cs_n || srst) !wp_ok |-> !stat_we;
   endproperty
   a_lock_refuses: assert property (p_lock_refuses) else $error("status written while locked");

   property p_no_prot_write;
      @(posedge spi_clock) disable iff (cs_n || srst)
         mem_we |-> !nvs_protected(stat.block_protect_hi, stat.block_protect_lo, addr);
   endproperty
   a_no_prot_write: assert property (p_no_prot_write) else $error("write into protected range");

   property p_whole_byte;
      @(posedge spi_clock) disable iff (cs_n || srst) mem_we |-> last_bit && state == ST_DATA && write_ok;
   endproperty
   a_whole_byte: assert property (p_whole_byte) else $error("commit on a partial byte");

   property p_commit_now;
      @(posedge spi_clock) disable iff (cs_n || srst)
         (frame_live && state == ST_DATA && last_bit && write_ok &&
          !nvs_protected(stat.block_protect_hi, stat.block_protect_lo, addr)) |-> mem_we;
   endproperty
   a_commit_now: assert property (p_commit_now) else $error("write byte not committed at once");

   property p_hold_freeze;
      @(posedge spi_clock) disable iff (cs_n || srst) !hold_n |=> $stable(bit_cnt) && $stable(state);
   endproperty
   a_hold_freeze: assert property (p_hold_freeze) else $error("state moved under suspend");

   property p_drive_only_read;
      @(posedge spi_clock) disable iff (cs_n || srst)
         so_oe |-> (state == ST_DATA && cmd == OP_MEM_RD) || (state == ST_STAT && cmd == OP_STAT_RD);
   endproperty
   a_drive_only_read: assert property (p_drive_only_read) else $error("output driven outside a read");

   property p_addr_low_bits;
      @(posedge spi_clock) disable iff (cs_n || srst)
         (frame_live && state == ST_ADDR && last_bit && !addr_hi) |=> addr[ADDR_W-1:8] == $past(rx[2:0]);
   endproperty
   a_addr_low_bits: assert property (p_addr_low_bits) else $error("upper address bits not dropped");

endmodule : nvs_spi_slave

`default_nettype wire

//--- testbench/nvs_host.sv
// Host master model that drives the serial link of the RAM slave.
// Assumes the bench calls one task at a time; the link clock half period is 7.5 ns.
`timescale 1ns/1ps
`default_nettype none

module nvs_host (
   // Link toward the slave
   output logic spi_clock,
   output logic cs_n,
   output logic si,
   output logic hold_n,
   // Answer from the slave
   input wire logic so,
   input wire logic so_oe
);
   logic cpol = 1'b0;
   logic last = 1'b0;
   logic oe_in_hold = 1'b0;

   // Late in time zero so the slave's edge-triggered clears see these edges
   initial begin
      cs_n <= 1'b1;
      hold_n <= 1'b1;
      spi_clock <= 1'b0;
      si <= 1'b0;
   end

   // Clock stands at the idle level of the chosen mode outside frames
   task automatic open_frame(input logic mode);
      cpol = mode;
      spi_clock = mode;
      #7.5 cs_n = 1'b0;
      #7.5;
   endtask : open_frame

   task automatic close_frame();
      #7.5 spi_clock = cpol;
      #7.5 cs_n = 1'b1;
      si = ~si;
      #15;
   endtask : close_frame

   // Released output reads as the inverse of its last level, so a float never matches by luck
   task automatic shift(input logic [7:0] tx, input int n, input int hold_at, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < n; i++) begin
         spi_clock = 1'b0;
         si = tx[7-i];
         if (i == hold_at) begin
            #7.5 hold_n = 1'b0;
            repeat (3) begin
               #7.5 spi_clock = 1'b1;
               si = ~si;
               oe_in_hold = oe_in_hold | so_oe;
               #7.5 spi_clock = 1'b0;
            end
            si = tx[7-i];
            #7.5 hold_n = 1'b1;
         end
         #7.5 spi_clock = 1'b1;
         rx[7-i] = so_oe ? so : ~last;
         last = rx[7-i];
         #7.5;
      end
   endtask : shift

   // Clock pulses with select high must reach nothing
   task automatic stray(input logic [7:0] tx);
      for (int i = 0; i < 8; i++) begin
         si = tx[7-i];
         #7.5 spi_clock = 1'b1;
         #7.5 spi_clock = 1'b0;
      end
   endtask : stray
endmodule : nvs_host

`default_nettype wire

//--- testbench/serial_nv_ram_spi_slave_bench.sv
// Self-checking bench for the serial RAM slave, driving it through the host model.
// Assumes the design package is compiled first; expected values are built here.
`timescale 1ns/1ps
`default_nettype none

module serial_nv_ram_spi_slave_bench;
   import nvs_pkg::*;
   logic clock = 1'b0;
   logic srst;
   logic wp_n = 1'b1;
   logic spi_clock, cs_n, si, hold_n, so, so_oe;
   logic standby, write_latch_flag, block_protect_hi, block_protect_lo;
   logic [7:0] r0, r1, v;
   logic [7:0] exp_m [4];
   logic [15:0] adr [4] = '{16'h03FF, 16'h0400, 16'h05FF, 16'h0600};
   logic prot;
   int miscompares = 0;
   int cmp_count = 0;

   always #50 clock = ~clock;

   nvs_spi_slave uut (.clock(clock), .srst(srst), .spi_clock(spi_clock), .cs_n(cs_n), .si(si),
      .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .standby(standby),
      .write_latch_flag(write_latch_flag), .block_protect_hi(block_protect_hi),
      .block_protect_lo(block_protect_lo));
   nvs_host host (.spi_clock(spi_clock), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   // Look half a period after the edge so the synchroniser's update has settled
   task automatic sync_wait();
      repeat (3) @(posedge clock);
      @(negedge clock);
   endtask : sync_wait

   task automatic flags(input logic [3:0] e);
      sync_wait();
      check({4'h0, standby, write_latch_flag, block_protect_hi, block_protect_lo}, {4'h0, e});
   endtask : flags

   task automatic cmd(input logic [7:0] op);
      logic [7:0] rx;
      host.open_frame(1'b0);
      host.shift(op, 8, -1, rx);
      host.close_frame();
   endtask : cmd

   task automatic stat(input logic [7:0] op, input logic [7:0] d, output logic [7:0] rx);
      logic [7:0] t;
      host.open_frame(1'b0);
      host.shift(op, 8, -1, t);
      host.shift(d, 8, -1, rx);
      host.close_frame();
   endtask : stat

   // Second byte is sent with n2 bits only, so a partial byte can be left behind
   task automatic mem_wr(input logic m, input logic [15:0] a, input logic [7:0] d, input logic [7:0] d2, input int n2);
      logic [7:0] t;
      host.open_frame(m);
      host.shift(OP_MEM_WR, 8, -1, t);
      host.shift(a[15:8], 8, -1, t);
      host.shift(a[7:0], 8, -1, t);
      host.shift(d, 8, -1, t);
      host.shift(d2, n2, -1, t);
      host.close_frame();
   endtask : mem_wr

   task automatic mem_rd(input logic m, input logic [15:0] a, input int hold_at, output logic [7:0] b0,
      output logic [7:0] b1);
      logic [7:0] t;
      host.open_frame(m);
      host.shift(OP_MEM_RD, 8, -1, t);
      host.shift(a[15:8], 8, -1, t);
      host.shift(a[7:0], 8, hold_at, t);
      host.shift(8'h00, 8, -1, b0);
      host.shift(8'h00, 8, -1, b1);
      host.close_frame();
   endtask : mem_rd

   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      complete_run();
   end

   initial begin
      // Asserted from time zero by an edge, so the link-side clear fires
      srst <= 1'b1;
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      repeat (2) @(posedge clock);
      flags(4'h8);
      host.stray(OP_SET_LATCH);
      flags(4'h8);
      cmd(OP_SET_LATCH);
      flags(4'hC);
      stat(OP_STAT_RD, 8'h00, v);
      check(v, 8'h02);
      cmd(OP_CLR_LATCH);
      flags(4'h8);
      cmd(OP_SET_LATCH);
      mem_wr(1'b1, 16'hF810, 8'hA5, 8'h3C, 8);
      flags(4'h8);
      cmd(OP_SET_LATCH);
      mem_wr(1'b0, 16'h0012, 8'h77, 8'h00, 0);
      mem_wr(1'b0, 16'h0012, 8'h11, 8'h00, 0);
      cmd(OP_SET_LATCH);
      mem_wr(1'b0, 16'h0011, 8'h5A, 8'hEE, 4);
      mem_rd(1'b0, 16'h0011, -1, r0, r1);
      check(r0, 8'h5A);
      check(r1, 8'h77);
      fork
         mem_rd(1'b1, 16'h2010, 3, r0, r1);
         flags(4'h0);
      join
      check(r0, 8'hA5);
      check(r1, 8'h5A);
      check({7'h0, host.oe_in_hold | so_oe}, 8'h00);
      @(posedge clock) wp_n <= 1'b0;
      cmd(OP_SET_LATCH);
      stat(OP_STAT_WR, 8'h8C, v);
      flags(4'h8);
      cmd(OP_SET_LATCH);
      mem_wr(1'b0, 16'h0020, 8'hC3, 8'h00, 0);
      mem_rd(1'b0, 16'h0020, -1, r0, r1);
      check(r0, 8'hC3);
      @(posedge clock) wp_n <= 1'b1;
      cmd(OP_SET_LATCH);
      stat(OP_STAT_WR, 8'h8C, v);
      stat(OP_STAT_RD, 8'h00, v);
      check(v, 8'h8C);
      for (int bp = 0; bp < 4; bp++) begin
         cmd(OP_SET_LATCH);
         stat(OP_STAT_WR, 8'(bp << 2), v);
         flags({2'b10, 2'(bp)});
         for (int j = 0; j < 4; j++) begin
            prot = (bp == 3) || (bp == 2 && adr[j] >= 16'h0400) || (bp == 1 && adr[j] >= 16'h0600);
            cmd(OP_SET_LATCH);
            mem_wr(1'b0, adr[j], 8'(bp * 16 + j), 8'h00, 0);
            if (!prot) begin
               exp_m[j] = 8'(bp * 16 + j);
            end
            mem_rd(1'b0, adr[j], -1, r0, r1);
            check(r0, exp_m[j]);
         end
      end
      complete_run();
   end
endmodule : serial_nv_ram_spi_slave_bench

`default_nettype wire
